// [hw/serial_cfg_pkg.sv]
// Constants and carrier types for the first serial port configuration bank.
// Assumes a classic Wishbone register bus with 32-bit data, one register per word.
package serial_cfg_pkg;
    // Printed indexes are not all multiples of four: byte address is four times the index.
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
    localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
    localparam logic [7:0] IDX_DMA_ZERO = 8'h74;
    localparam logic [7:0] IDX_DMA_ONE = 8'h75;
    localparam logic [7:0] IDX_PORT_CFG = 8'hF0;
    // Window for the serial port's own registers, reached through this bank.
    localparam logic [7:0] IDX_PORT_WIN_BASE = 8'h80;
    localparam logic [7:0] IDX_PORT_WIN_MASK = 8'hF8;

    localparam logic [7:0] RST_ACTIVATE = 8'h00;
    localparam logic [7:0] RST_BASE_HIGH = 8'h03;
    localparam logic [7:0] RST_BASE_LOW = 8'hF8;
    localparam logic [7:0] RST_IRQ_NUM = 8'h04;
    localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
    localparam logic [7:0] VAL_NO_DMA = 8'h04;
    localparam logic [7:0] RST_PORT_CFG = 8'h02;

    localparam logic [7:0] MASK_BASE_HIGH = 8'h07;
    localparam logic [7:0] MASK_BASE_LOW = 8'hF8;
    localparam logic [7:0] MASK_IRQ_TYPE_WR = 8'h02;

    localparam int BIT_BANK_EN = 7;
    localparam int BIT_BUSY = 2;
    localparam int BIT_POWER = 1;
    localparam int BIT_TRISTATE = 0;
    localparam int BIT_ACTIVE = 0;
    localparam int BIT_WAKE_EN = 4;

    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] baseHigh;
        logic [7:0] baseLow;
        logic [7:0] irqNum;
        logic [7:0] irqType;
        logic [7:0] portCfg;
    } cfg_regs_type;

    typedef struct packed {
        logic portActive;
        logic clockRun;
        logic bankSwitchEn;
        logic pinsTristate;
        logic portAccessEn;
        logic ringWakeArm;
    } port_ctrl_type;
endpackage

// [hw/sync_two_flop.sv]
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are levels that stay put long enough to be seen.
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;

    initial begin
        if (WIDTH < 1) begin
            $error("sync_two_flop: WIDTH must be at least 1.");
        end
    end

    // The first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (srst) begin
            stage1_q <= '0;
            syncOut <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule // sync_two_flop

// [hw/serial_port_one_config_bank.sv]
// Configuration register bank for the first serial port logical device.
// Assumes a classic Wishbone master; the serial port datapath sits outside and uses the control outputs.
//
// Functional notes
// (R1) Activation register at 30h, read/write, resets to 00h so port starts inactive.
// (R2) Base high byte at 60h resets 03h; bits 7..3 read zero, ignore writes.
// (R3) Base low byte at 61h resets F8h; bits 2..0 fixed zero, read-only.
// (R4) Interrupt number and wake enable at 70h, read/write, resets to 04h.
// (R5) Interrupt type at 71h resets 03h; only bit 1 writable.
// (R6) Indexes 74h and 75h read 04h: no DMA channel assigned.
// (R7) Port configuration register at F0h, read/write, resets to 02h.
// (R8) Config bit 7 permits bank switching when set; clear by default.
// (R9) Config bit 2 read-only, shows transfer in progress, zero by default.
// (R10) Bit 1 clear while active: port clock gated, outputs default, registers kept.
// (R11) Low power still lets ring indicate raise an interrupt; register access allowed.
// (R12) Clearing activation also blocks access to the port's own registers.
// (R13) Bit 1 set, the default, runs the port clock fully while active.
// (R14) Bit 0 set and device inactive puts all port outputs in high impedance.
// (R15) Config bits 6..3 reserved: read zero, writes ignored.
`timescale 1ns/1ps
module serial_port_one_config_bank (
    input wire logic clk,
    input wire logic srst,
    // Classic Wishbone slave.
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [9:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatI,
    output logic [31:0] wbDatO,
    output logic wbAck,
    // Status from the serial port datapath (same clock).
    input wire logic transferBusy,
    // Ring indicate pin, asynchronous.
    input wire logic ringIndicateInput,
    // Read data from the serial port's own registers (same clock).
    input wire logic [7:0] portRegRdata,
    // Control towards the serial port.
    output logic portClockEn,
    output logic portOutputsDefault,
    output logic portOutputsTristate,
    output logic bankSwitchEn,
    output logic portRegStrobe,
    output logic portRegWe,
    output logic [2:0] portRegAddr,
    output logic [7:0] portRegWdata,
    output logic ringWakeIrq,
    output logic [15:0] portBaseAddr,
    output logic [7:0] irqSelect,
    output logic irqTypeBit
);
    serial_cfg_pkg::cfg_regs_type regs_q;
    serial_cfg_pkg::port_ctrl_type ctrl;
    logic ringSync;
    logic ringSync_q;
    logic busySync;
    logic [7:0] index;
    logic request;
    logic writeTake;
    logic lowLaneWrite;
    logic portWinHit;
    logic [7:0] readByte;

    // One decode serves the read mux, the window strobe and the layout check below.
    function automatic logic is_window(input logic [7:0] idx);
        is_window = (idx & serial_cfg_pkg::IDX_PORT_WIN_MASK) == serial_cfg_pkg::IDX_PORT_WIN_BASE;
    endfunction

    // The window must be aligned and clear of the mapped indexes, and the fixed bits must stay fixed.
    initial begin
        if ((serial_cfg_pkg::IDX_PORT_WIN_BASE & ~serial_cfg_pkg::IDX_PORT_WIN_MASK) != 8'h00) begin
            $error("serial_port_one_config_bank: window base is not aligned to its mask.");
        end
        if (serial_cfg_pkg::IDX_PORT_WIN_MASK != 8'hF8) begin
            $error("serial_port_one_config_bank: the window must span eight indexes to fill portRegAddr.");
        end
        if (is_window(serial_cfg_pkg::IDX_ACTIVATE) || is_window(serial_cfg_pkg::IDX_BASE_HIGH)
            || is_window(serial_cfg_pkg::IDX_BASE_LOW) || is_window(serial_cfg_pkg::IDX_IRQ_NUM)
            || is_window(serial_cfg_pkg::IDX_IRQ_TYPE) || is_window(serial_cfg_pkg::IDX_DMA_ZERO)
            || is_window(serial_cfg_pkg::IDX_DMA_ONE) || is_window(serial_cfg_pkg::IDX_PORT_CFG)) begin
            $error("serial_port_one_config_bank: window overlaps a configuration register.");
        end
        if ((serial_cfg_pkg::MASK_BASE_HIGH & 8'hF8) != 8'h00
            || (serial_cfg_pkg::MASK_BASE_LOW & 8'h07) != 8'h00) begin
            $error("serial_port_one_config_bank: fixed base address bits would become writable.");
        end
        if (serial_cfg_pkg::MASK_IRQ_TYPE_WR != 8'h02) begin
            $error("serial_port_one_config_bank: only bit 1 of the interrupt type may be writable.");
        end
        if (serial_cfg_pkg::BIT_WAKE_EN > 7 || serial_cfg_pkg::BIT_BANK_EN > 7) begin
            $error("serial_port_one_config_bank: a field position lies outside the byte.");
        end
    end

    // Ring indicate is a pin, so it crosses two flops before any logic reads it.
    sync_two_flop #(.WIDTH(1)) ringSyncInst (
        .clk(clk),
        .srst(srst),
        .asyncIn(ringIndicateInput),
        .syncOut(ringSync)
    );

    // Busy comes from logic on this clock and is read live without synchronising.
    assign busySync = transferBusy;
    assign index = wbAdr[9:2];
    // A request is taken only while ack is low, so a held strobe is answered every second cycle.
    assign request = wbCyc && wbStb && !wbAck;
    assign writeTake = request && wbWe;
    assign lowLaneWrite = writeTake && wbSel[0];
    assign portWinHit = is_window(index);

    always_comb begin
        ctrl.portActive = regs_q.activate[serial_cfg_pkg::BIT_ACTIVE];
        ctrl.clockRun = ctrl.portActive && regs_q.portCfg[serial_cfg_pkg::BIT_POWER]; // [R10] [R13]
        ctrl.bankSwitchEn = regs_q.portCfg[serial_cfg_pkg::BIT_BANK_EN]; // [R8]
        ctrl.pinsTristate = !ctrl.portActive && regs_q.portCfg[serial_cfg_pkg::BIT_TRISTATE]; // [R14]
        ctrl.portAccessEn = ctrl.portActive; // [R12]
        // Ring wake stays armed in low power; the wake enable is bit 4 of the interrupt number register.
        ctrl.ringWakeArm = ctrl.portActive && regs_q.irqNum[serial_cfg_pkg::BIT_WAKE_EN]; // [R11]
    end

    // Read-only bits keep their stored value; only the writable mask takes new data.
    function automatic logic [7:0] merge_byte(input logic [7:0] oldVal, input logic [7:0] newVal,
                                              input logic [7:0] writable);
        merge_byte = (oldVal & ~writable) | (newVal & writable);
    endfunction

    // Configuration register writes take effect at the edge that raises ack.
    always_ff @(posedge clk) begin
        if (srst) begin
            regs_q.activate <= serial_cfg_pkg::RST_ACTIVATE; // [R1]
            regs_q.baseHigh <= serial_cfg_pkg::RST_BASE_HIGH; // [R2]
            regs_q.baseLow <= serial_cfg_pkg::RST_BASE_LOW; // [R3]
            regs_q.irqNum <= serial_cfg_pkg::RST_IRQ_NUM; // [R4]
            regs_q.irqType <= serial_cfg_pkg::RST_IRQ_TYPE; // [R5]
            regs_q.portCfg <= serial_cfg_pkg::RST_PORT_CFG; // [R7]
        end else if (lowLaneWrite) begin
            unique case (index)
                serial_cfg_pkg::IDX_ACTIVATE: begin
                    regs_q.activate <= wbDatI[7:0]; // [R1]
                end
                serial_cfg_pkg::IDX_BASE_HIGH: begin
                    regs_q.baseHigh <= merge_byte(regs_q.baseHigh, wbDatI[7:0], serial_cfg_pkg::MASK_BASE_HIGH); // [R2]
                end
                serial_cfg_pkg::IDX_BASE_LOW: begin
                    regs_q.baseLow <= merge_byte(regs_q.baseLow, wbDatI[7:0], serial_cfg_pkg::MASK_BASE_LOW); // [R3]
                end
                serial_cfg_pkg::IDX_IRQ_NUM: begin
                    regs_q.irqNum <= wbDatI[7:0]; // [R4]
                end
                serial_cfg_pkg::IDX_IRQ_TYPE: begin
                    regs_q.irqType <= merge_byte(regs_q.irqType, wbDatI[7:0], serial_cfg_pkg::MASK_IRQ_TYPE_WR); // [R5]
                end
                serial_cfg_pkg::IDX_PORT_CFG: begin
                    // Only bits 7, 1 and 0 are stored; busy and reserved bits are not.
                    regs_q.portCfg[serial_cfg_pkg::BIT_BANK_EN] <= wbDatI[serial_cfg_pkg::BIT_BANK_EN]; // [R8] [R15]
                    regs_q.portCfg[serial_cfg_pkg::BIT_POWER] <= wbDatI[serial_cfg_pkg::BIT_POWER]; // [R10] [R13]
                    regs_q.portCfg[serial_cfg_pkg::BIT_TRISTATE] <= wbDatI[serial_cfg_pkg::BIT_TRISTATE]; // [R14]
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; the port window answers with the port's own data only while active.
    always_comb begin
        readByte = 8'h00;
        if (portWinHit) begin
            readByte = ctrl.portAccessEn ? portRegRdata : 8'h00; // [R12]
        end else begin
            unique case (index)
                serial_cfg_pkg::IDX_ACTIVATE: readByte = regs_q.activate;
                serial_cfg_pkg::IDX_BASE_HIGH: readByte = regs_q.baseHigh & serial_cfg_pkg::MASK_BASE_HIGH; // [R2]
                serial_cfg_pkg::IDX_BASE_LOW: readByte = regs_q.baseLow & serial_cfg_pkg::MASK_BASE_LOW; // [R3]
                serial_cfg_pkg::IDX_IRQ_NUM: readByte = regs_q.irqNum;
                serial_cfg_pkg::IDX_IRQ_TYPE: readByte = regs_q.irqType;
                serial_cfg_pkg::IDX_DMA_ZERO: readByte = serial_cfg_pkg::VAL_NO_DMA; // [R6]
                serial_cfg_pkg::IDX_DMA_ONE: readByte = serial_cfg_pkg::VAL_NO_DMA; // [R6]
                serial_cfg_pkg::IDX_PORT_CFG: begin
                    // Reserved bits 6..3 keep the zero given above.
                    readByte[serial_cfg_pkg::BIT_BANK_EN] = regs_q.portCfg[serial_cfg_pkg::BIT_BANK_EN]; // [R15]
                    readByte[serial_cfg_pkg::BIT_BUSY] = busySync; // [R9]
                    readByte[serial_cfg_pkg::BIT_POWER] = regs_q.portCfg[serial_cfg_pkg::BIT_POWER];
                    readByte[serial_cfg_pkg::BIT_TRISTATE] = regs_q.portCfg[serial_cfg_pkg::BIT_TRISTATE];
                end
                default: readByte = 8'h00;
            endcase
        end
    end

    // Every request is answered one cycle later; unmapped indexes read zero and drop writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= request;
        end
    end

    // Read data is captured with the ack and then holds until the next read.
    always_ff @(posedge clk) begin
        if (srst) begin
            wbDatO <= 32'h0000_0000;
        end else if (request && !wbWe) begin
            wbDatO <= {24'h00_0000, readByte};
        end
    end

    // Port register window: a one-cycle strobe, suppressed while the device is inactive.
    always_ff @(posedge clk) begin
        if (srst) begin
            portRegStrobe <= 1'b0;
        end else begin
            portRegStrobe <= request && portWinHit && ctrl.portAccessEn
                             && (!wbWe || wbSel[0]); // [R12] [R11]
        end
    end

    // The qualifiers hold after the strobe so the port may sample them late.
    always_ff @(posedge clk) begin
        if (srst) begin
            portRegWe <= 1'b0;
            portRegAddr <= 3'h0;
            portRegWdata <= 8'h00;
        end else if (request && portWinHit) begin
            portRegWe <= wbWe;
            portRegAddr <= index[2:0];
            portRegWdata <= wbDatI[7:0];
        end
    end

    // Ring indicate wakes on its rising edge even with the port clock gated in low power, though not while the device is inactive.
    always_ff @(posedge clk) begin
        if (srst) begin
            ringSync_q <= 1'b0;
        end else begin
            ringSync_q <= ringSync;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ringWakeIrq <= 1'b0;
        end else begin
            ringWakeIrq <= ctrl.ringWakeArm && ringSync && !ringSync_q; // [R11]
        end
    end

    // Clock gate and default-state drive move together in low power and while inactive.
    always_ff @(posedge clk) begin
        if (srst) begin
            portClockEn <= 1'b0;
            portOutputsDefault <= 1'b1;
        end else begin
            portClockEn <= ctrl.clockRun; // [R10] [R13]
            portOutputsDefault <= !ctrl.clockRun; // [R10]
        end
    end

    // Tri-state applies only while inactive, whatever the power bit says.
    always_ff @(posedge clk) begin
        if (srst) begin
            portOutputsTristate <= 1'b0;
        end else begin
            portOutputsTristate <= ctrl.pinsTristate; // [R14]
        end
    end

    // Bank switching enable is passed on whatever the activation state.
    always_ff @(posedge clk) begin
        if (srst) begin
            bankSwitchEn <= 1'b0;
        end else begin
            bankSwitchEn <= ctrl.bankSwitchEn; // [R8]
        end
    end

    // The fixed base bits are masked again here so the decoder never sees a stray one.
    always_ff @(posedge clk) begin
        if (srst) begin
            portBaseAddr <= {serial_cfg_pkg::RST_BASE_HIGH, serial_cfg_pkg::RST_BASE_LOW};
        end else begin
            portBaseAddr <= {regs_q.baseHigh & serial_cfg_pkg::MASK_BASE_HIGH,
                             regs_q.baseLow & serial_cfg_pkg::MASK_BASE_LOW}; // [R2] [R3]
        end
    end

    // Interrupt routing is passed on as stored; the wake enable bit rides in irqSelect too.
    always_ff @(posedge clk) begin
        if (srst) begin
            irqSelect <= serial_cfg_pkg::RST_IRQ_NUM;
            irqTypeBit <= serial_cfg_pkg::RST_IRQ_TYPE[1];
        end else begin
            irqSelect <= regs_q.irqNum; // [R4]
            irqTypeBit <= regs_q.irqType[1]; // [R5]
        end
    end
endmodule // serial_port_one_config_bank

// [test/serial_cfg_chk.sv]
// Concurrent checks on the ports of the serial port configuration bank.
// Assumes a classic Wishbone master that drops its request one cycle after ack.
`timescale 1ns/1ps
module serial_cfg_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [9:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatO,
    input wire logic wbAck,
    input wire logic transferBusy,
    input wire logic ringIndicateInput,
    input wire logic portClockEn,
    input wire logic portOutputsDefault,
    input wire logic portOutputsTristate,
    input wire logic portRegStrobe,
    input wire logic ringWakeIrq,
    input wire logic [15:0] portBaseAddr,
    input wire logic [7:0] irqSelect
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence rd_s(logic [9:0] a);
        wbCyc && wbStb && !wbAck && !wbWe && wbAdr == a;
    endsequence
    sequence win_s;
        wbCyc && wbStb && !wbAck && wbAdr[9:5] == 5'h10;
    endsequence
    ack_pulse_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("ack is not a single pulse");
    busy_read_a: assert property (rd_s(10'h3C0) |=> wbDatO[2] == $past(transferBusy) && wbDatO[6:3] == 4'h0)
        else $error("config readback wrong");
    no_dma_a: assert property (rd_s(10'h1D0) or rd_s(10'h1D4) |=> wbDatO[7:0] == 8'h04)
        else $error("dma report wrong");
    base_fixed_a: assert property (portBaseAddr[15:11] == 5'h00 && portBaseAddr[2:0] == 3'h0)
        else $error("fixed base bits not zero");
    clock_gate_a: assert property (portOutputsDefault == !portClockEn)
        else $error("outputs default not tied to clock gate");
    tristate_idle_a: assert property (portOutputsTristate |-> !portClockEn)
        else $error("tristate while running");
    strobe_cause_a: assert property (portRegStrobe |-> $past(wbCyc && wbStb && !wbAck && wbAdr[9:5] == 5'h10))
        else $error("strobe without window request");
    ring_wake_a: assert property (ringWakeIrq |-> irqSelect[4] && $past(ringIndicateInput, 2) ##1 !ringWakeIrq)
        else $error("wake pulse without cause");
    window_once_a: assert property (win_s ##1 portRegStrobe |=> !portRegStrobe)
        else $error("strobe longer than one cycle");
    lane_skip_a: assert property (wbCyc && wbStb && !wbAck && wbWe && !wbSel[0] && wbAdr[9:5] == 5'h10 |=> !portRegStrobe)
        else $error("window strobe without lane zero");
endmodule // serial_cfg_chk

// [test/testbench.sv]
// Self-checking bench for the serial port configuration bank.
// Assumes the package, design and checker files are compiled before it.
`timescale 1ns/1ps
bind serial_port_one_config_bank serial_cfg_chk serial_cfg_chk_i (
    .clk(clk),
    .srst(srst),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbAdr(wbAdr),
    .wbSel(wbSel),
    .wbDatO(wbDatO),
    .wbAck(wbAck),
    .transferBusy(transferBusy),
    .ringIndicateInput(ringIndicateInput),
    .portClockEn(portClockEn),
    .portOutputsDefault(portOutputsDefault),
    .portOutputsTristate(portOutputsTristate),
    .portRegStrobe(portRegStrobe),
    .ringWakeIrq(ringWakeIrq),
    .portBaseAddr(portBaseAddr),
    .irqSelect(irqSelect)
);
module testbench;
    logic clk, srst, wbCyc, wbStb, wbWe, wbAck, transferBusy, ringIndicateInput;
    logic [9:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatI, wbDatO;
    logic [7:0] portRegRdata, portRegWdata, irqSelect, rd;
    logic portClockEn, portOutputsDefault, portOutputsTristate, bankSwitchEn;
    logic portRegStrobe, portRegWe, ringWakeIrq, irqTypeBit;
    logic [2:0] portRegAddr;
    logic [15:0] portBaseAddr;
    int mismatches = 0, compares = 0, strobes = 0, rings = 0;
    serial_port_one_config_bank serial_port_one_config_bank_i (
        .clk(clk),
        .srst(srst),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbWe(wbWe),
        .wbAdr(wbAdr),
        .wbSel(wbSel),
        .wbDatI(wbDatI),
        .wbDatO(wbDatO),
        .wbAck(wbAck),
        .transferBusy(transferBusy),
        .ringIndicateInput(ringIndicateInput),
        .portRegRdata(portRegRdata),
        .portClockEn(portClockEn),
        .portOutputsDefault(portOutputsDefault),
        .portOutputsTristate(portOutputsTristate),
        .bankSwitchEn(bankSwitchEn),
        .portRegStrobe(portRegStrobe),
        .portRegWe(portRegWe),
        .portRegAddr(portRegAddr),
        .portRegWdata(portRegWdata),
        .ringWakeIrq(ringWakeIrq),
        .portBaseAddr(portBaseAddr),
        .irqSelect(irqSelect),
        .irqTypeBit(irqTypeBit)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (portRegStrobe === 1'b1) strobes++;
        if (ringWakeIrq === 1'b1) rings++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; the answer is taken at the edge where ack is seen high.
    task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] d);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbDatI <= {24'h000000, d};
        @(posedge clk);
        // Ack rises at the edge that takes the request and is seen high at the next.
        while (wbAck !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(16'(n), 16'h0001);
        rd = wbDatO[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic test_reset;
        logic [15:0] t[9] = '{16'h3000, 16'h6003, 16'h61F8, 16'h7004, 16'h7103, 16'h7404, 16'h7504, 16'hF002,
            16'h4000};
        foreach (t[i]) begin
            bus(t[i][15:8], 1'b0, 8'h00);
            chk(rd, t[i][7:0]);
        end
        chk(portBaseAddr, 16'h03F8);
        chk({irqSelect, 7'h00, irqTypeBit}, 16'h0401);
        chk({portClockEn, portOutputsTristate, bankSwitchEn}, 16'h0000);
        $display("test_reset done");
    endtask
    task automatic test_masks;
        logic [23:0] t[6] = '{24'h60FF07, 24'h61FFF8, 24'h70ABAB, 24'h710001, 24'h740004, 24'hF0FF83};
        foreach (t[i]) begin
            bus(t[i][23:16], 1'b1, t[i][15:8]);
            bus(t[i][23:16], 1'b0, 8'h00);
            chk(rd, t[i][7:0]);
        end
        chk(portBaseAddr, 16'h07F8);
        chk({bankSwitchEn, portOutputsTristate, portClockEn}, 16'h0006);
        $display("test_masks done");
    endtask
    task automatic test_power;
        bus(8'h30, 1'b1, 8'h01);
        chk({portClockEn, portOutputsDefault, portOutputsTristate}, 16'h0004);
        bus(8'hF0, 1'b1, 8'h00);
        chk({portClockEn, portOutputsDefault}, 16'h0001);
        bus(8'h60, 1'b0, 8'h00);
        chk(rd, 8'h07);
        bus(8'hF0, 1'b1, 8'h01);
        bus(8'h30, 1'b1, 8'h00);
        chk({portClockEn, portOutputsTristate}, 16'h0001);
        $display("test_power done");
    endtask
    task automatic test_window;
        bus(8'h30, 1'b1, 8'h01);
        transferBusy <= 1'b1;
        bus(8'hF0, 1'b0, 8'h00);
        chk(rd, 8'h05);
        transferBusy <= 1'b0;
        bus(8'h81, 1'b1, 8'h5A);
        chk({strobes[7:0], portRegWe, portRegAddr, 4'h0}, 16'h0190);
        chk(portRegWdata, 8'h5A);
        portRegRdata <= 8'hC3;
        bus(8'h82, 1'b0, 8'h00);
        chk(rd, 8'hC3);
        wbSel <= 4'h0;
        bus(8'h83, 1'b1, 8'h11);
        wbSel <= 4'h1;
        chk(16'(strobes), 16'h0002);
        bus(8'h30, 1'b1, 8'h00);
        bus(8'h82, 1'b0, 8'h00);
        chk({rd, strobes[7:0]}, 16'h0002);
        $display("test_window done");
    endtask
    task automatic test_ring;
        bus(8'h30, 1'b1, 8'h01);
        bus(8'h70, 1'b1, 8'h14);
        ringIndicateInput <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(rings), 16'h0001);
        ringIndicateInput <= 1'b0;
        bus(8'h70, 1'b1, 8'h04);
        ringIndicateInput <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(rings), 16'h0001);
        ringIndicateInput <= 1'b0;
        $display("test_ring done");
    endtask
    task automatic complete_run;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        $display("Error at %0t: time limit expired", $time);
        complete_run();
    end
    initial begin
        {srst, wbCyc, wbStb, wbWe, transferBusy, ringIndicateInput} = 6'b100000;
        {wbAdr, wbSel, wbDatI, portRegRdata} = {10'h000, 4'h1, 32'h00000000, 8'h00};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_masks();
        test_power();
        test_window();
        test_ring();
        complete_run();
    end
endmodule // testbench
